// ### hw/adcctl_pkg.sv
// Package for the converter channel and timing control block.
// Assumes a single 25 MHz clock domain and a 32-bit Avalon-MM register bus.
package adcctl_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL0 = 4'h0;
  localparam logic [3:0] ADDR_CTRL1 = 4'h4;
  localparam logic [3:0] ADDR_CTRL2 = 4'h8;
  localparam logic [3:0] ADDR_RES_HI = 4'hC;
  localparam logic [3:0] ADDR_RES_LO = 4'h0; // Low byte lives at word 4 (see ADDR_HI_BANK)
  localparam logic ADDR_HI_BANK = 1'b1; // Address bit 4 selects result low byte
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL0_WMASK = 8'h3F;
  localparam logic [7:0] CTRL1_WMASK = 8'h3F;
  localparam logic [7:0] CTRL2_WMASK = 8'hBF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT = 0;
  localparam int BUSY_BIT = 1;
  localparam int CHAN_LSB = 2;
  localparam int NEGREF_BIT = 5;
  localparam int POSREF_BIT = 4;
  localparam int JUSTIFY_BIT = 7;
  localparam int ACQ_LSB = 3;

  // ----------------------------------------------------------------
  // Converter figures
  // ----------------------------------------------------------------
  localparam int NUM_INPUTS = 12;
  localparam int RESULT_BITS = 10;
  localparam logic [3:0] CONV_PERIODS = 4'hB; // Periods per conversion
  localparam logic [3:0] LAST_CHANNEL = 4'hB;
  localparam logic [3:0] ALL_ANALOG_MAX = 4'h3;
  localparam logic [2:0] CLK_RC_A = 3'h7;
  localparam logic [2:0] CLK_RC_B = 3'h3;
  localparam logic [6:0] RC_HALF_DIV = 7'h04; // Half period of internal RC clock in ref_clk
  localparam logic [6:0] INSTR_CYCLE_CLKS = 7'h04; // One instruction cycle in ref_clk
  localparam logic [4:0] ACQ_DECODE [8] = '{5'h00, 5'h02, 5'h04, 5'h06,
                                            5'h08, 5'h0C, 5'h10, 5'h14};
  localparam logic [6:0] DIV_DECODE [8] = '{7'h02, 7'h08, 7'h20, 7'h00,
                                            7'h04, 7'h10, 7'h40, 7'h00};

  typedef enum logic [1:0] {ADC_IDLE, ADC_WAIT, ADC_ACQ, ADC_CONV} adcctl_state_t;

  // Conversion request toward the analog side
  typedef struct packed {
    logic [3:0] channel;
    logic neg_ref_ext;
    logic pos_ref_ext;
  } adcctl_sel_t;

endpackage : adcctl_pkg

// ### hw/adcctl_tick.sv
// Conversion clock period tick generator.
// Assumes ref_clk as oscillator; a full period is twice the half count.
`timescale 1ns/1ps
module adcctl_tick
  import adcctl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [6:0] period,
  // Tick out
  output logic tick
);

  logic [6:0] cnt_reg;

  // Count ref_clk cycles, pulse once per period
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 7'h00;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 7'h00;
      tick <= 1'b0;
    end else if (cnt_reg >= period - 7'h01) begin
      cnt_reg <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
      tick <= 1'b0;
    end
  end

endmodule : adcctl_tick

// ### hw/adcctl_top.sv
// Control logic of a 10-bit successive-approximation converter with 12 inputs.
// Assumes an Avalon-MM master on ref_clk and an analog array that returns the
// result bits when asked; comparator data are sampled through two flip-flops.
// ----------------------------------------------------------------
// Summary of operation
// - Twelve selectable inputs, ten-bit result per conversion.
// - Five registers: result high, result low, three control registers.
// - Control zero bits 5..2 pick input 0..11 by binary code.
// - Codes 12..15 select no input; conversion measures a floating node.
// - Control zero bit 1 reads 1 while converting, 0 when idle.
// - Control zero bit 0 enables the converter.
// - Unimplemented bits 7..6 of controls zero, one, bit 6 of two read zero.
// - Control one bit 5: negative reference external input two or ground.
// - Control one bit 4: positive reference external input three or supply.
// - Port codes 0..3 all analog, code 15 all digital.
// - Control two bit 7: 1 right justified, 0 left justified.
// - Bits 5..3 set acquisition of 0..20 conversion clock periods.
// - Bits 2..0 select RC clock or oscillator divided 2..64.
// - RC clock source adds one instruction cycle before clock starts.
// - On completion store result, clear busy, set done flag.
// - Each conversion takes eleven conversion clock periods.
// - Non-zero acquisition samples first then converts; zero converts at once.
// - Reset clears control registers and aborts any conversion.
// ----------------------------------------------------------------
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
module adcctl_top
  import adcctl_pkg::*;
#(
  parameter int N_INPUTS = NUM_INPUTS,
  parameter int RES_W = RESULT_BITS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Analog side
  output adcctl_sel_t analog_sel,
  output logic [N_INPUTS-1:0] pin_is_analog,
  output logic sample_on,
  output logic conv_clk_tick,
  input wire logic [RES_W-1:0] comparator_result,
  // Event
  output logic conversion_done_flag
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0] converter_control_zero;
  logic [7:0] converter_reference_port_config;
  logic [7:0] converter_timing_format;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;
  logic busy_reg;
  adcctl_state_t state_reg;
  logic [6:0] wait_reg;
  logic [4:0] acq_cnt_reg;
  logic [3:0] conv_cnt_reg;
  logic [RES_W-1:0] cmp_meta_reg;
  logic [RES_W-1:0] cmp_sync_reg;
  logic tick;
  logic tick_run;
  logic [6:0] tick_period;
  logic go_write;
  logic conv_end;
  logic [15:0] result_pair;

  // Decoded fields
  logic [2:0] clk_sel;
  logic [2:0] acq_sel;
  logic use_rc;
  assign clk_sel = converter_timing_format[2:0];
  assign acq_sel = converter_timing_format[ACQ_LSB +: 3];
  assign use_rc = (clk_sel == CLK_RC_A) || (clk_sel == CLK_RC_B);

  // Start request: an accepted write to control zero that sets both the
  // start and enable bits while the sequencer is idle. Enable may be set
  // by the same write, so the sequencer must not use the old enable here.
  assign go_write = avs_write && !avs_waitrequest && !avs_address[4]
                    && (avs_address[3:0] == ADDR_CTRL0)
                    && avs_byteenable[0] && avs_writedata[BUSY_BIT]
                    && avs_writedata[ENABLE_BIT] && (state_reg == ADC_IDLE);
  assign conv_end = (state_reg == ADC_CONV) && tick && (conv_cnt_reg == CONV_PERIODS - 4'h1);

  // ----------------------------------------------------------------
  // Conversion clock generator
  // ----------------------------------------------------------------
  assign tick_run = (state_reg == ADC_ACQ) || (state_reg == ADC_CONV);
  // The divider restarts whenever it stops, so the first period after a
  // start is always a full one.
  // RC source modelled as fixed divider from ref_clk
  assign tick_period = use_rc ? (RC_HALF_DIV << 1) : DIV_DECODE[clk_sel];

  adcctl_tick u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(tick_run),
    .period(tick_period),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmp_meta_reg <= '0;
      cmp_sync_reg <= '0;
    end else begin
      cmp_meta_reg <= comparator_result;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  // Writes land at the answer edge, where waitrequest is low; bits with no
  // storage are masked so that they read back as zero.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      converter_control_zero <= CTRL_RESET;
      converter_reference_port_config <= CTRL_RESET;
      converter_timing_format <= CTRL_RESET;
    end else if (avs_write && !avs_waitrequest && !avs_address[4] && avs_byteenable[0]) begin
      unique case (avs_address[3:0])
        ADDR_CTRL0: converter_control_zero <= avs_writedata[7:0] & CTRL0_WMASK;
        ADDR_CTRL1: converter_reference_port_config <= avs_writedata[7:0] & CTRL1_WMASK;
        ADDR_CTRL2: converter_timing_format <= avs_writedata[7:0] & CTRL2_WMASK;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // Start waits (one instruction cycle when the RC source is chosen), then
  // acquires for the programmed periods and converts for eleven. Clearing
  // enable drops back to idle at once, which aborts a conversion.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ADC_IDLE;
      busy_reg <= 1'b0;
      wait_reg <= 7'h00;
      acq_cnt_reg <= 5'h00;
      conv_cnt_reg <= 4'h0;
    end else if (!converter_control_zero[ENABLE_BIT] && !go_write) begin
      state_reg <= ADC_IDLE;
      busy_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ADC_IDLE: begin
          if (go_write) begin
            busy_reg <= 1'b1;
            wait_reg <= use_rc ? INSTR_CYCLE_CLKS : 7'h00;
            acq_cnt_reg <= ACQ_DECODE[acq_sel];
            conv_cnt_reg <= 4'h0;
            state_reg <= ADC_WAIT;
          end
        end
        ADC_WAIT: begin
          if (wait_reg != 7'h00) begin
            wait_reg <= wait_reg - 7'h01;
          end else begin
            state_reg <= (acq_cnt_reg == 5'h00) ? ADC_CONV : ADC_ACQ;
          end
        end
        ADC_ACQ: begin
          if (tick) begin
            acq_cnt_reg <= acq_cnt_reg - 5'h01;
            if (acq_cnt_reg == 5'h01) begin
              state_reg <= ADC_CONV;
            end
          end
        end
        ADC_CONV: begin
          if (tick) begin
            conv_cnt_reg <= conv_cnt_reg + 4'h1;
            if (conv_end) begin
              busy_reg <= 1'b0;
              state_reg <= ADC_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result store and justification
  // ----------------------------------------------------------------
  always_comb begin
    if (converter_timing_format[JUSTIFY_BIT]) begin
      result_pair = {{(16-RES_W){1'b0}}, cmp_sync_reg};
    end else begin
      result_pair = {cmp_sync_reg, {(16-RES_W){1'b0}}};
    end
  end

  // Result bytes hold their value across reset, as on power-up, and are
  // written only by a conversion that is still enabled at its end
  always_ff @(posedge ref_clk) begin
    if (conv_end && converter_control_zero[ENABLE_BIT]) begin
      result_high_byte <= result_pair[15:8];
      result_low_byte <= result_pair[7:0];
    end
  end

  // Done flag pulses one cycle per completed conversion
  // Gated by enable so that a disable on the last tick reports nothing
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conversion_done_flag <= 1'b0;
    end else begin
      conversion_done_flag <= conv_end && converter_control_zero[ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Analog side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      analog_sel <= '0;
      sample_on <= 1'b0;
      conv_clk_tick <= 1'b0;
    end else begin
      // Codes above the last channel drive a floating node (no pin)
      analog_sel.channel <= converter_control_zero[CHAN_LSB +: 4];
      analog_sel.neg_ref_ext <= converter_reference_port_config[NEGREF_BIT];
      analog_sel.pos_ref_ext <= converter_reference_port_config[POSREF_BIT];
      sample_on <= converter_control_zero[ENABLE_BIT] && (state_reg != ADC_CONV);
      conv_clk_tick <= tick && (state_reg == ADC_CONV);
    end
  end

  // Pin analog map: pin i analog while code <= 3 or pin index below 15-code
  genvar gi;
  generate
    for (gi = 0; gi < N_INPUTS; gi++) begin : g_pin
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          pin_is_analog[gi] <= 1'b1;
        end else begin
          pin_is_analog[gi] <= (converter_reference_port_config[3:0] <= ALL_ANALOG_MAX)
            || (gi < (15 - int'(converter_reference_port_config[3:0])));
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Every transfer, read or write, waits exactly one cycle: waitrequest
  // idles high, drops for the cycle after a request is first seen and
  // rises again at the edge that completes the transfer. This keeps the
  // answer in a flip-flop; a master must not assume zero-wait writes.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
    end
  end

  // ----------------------------------------------------------------
  // Bus read path
  // ----------------------------------------------------------------
  // Read data are loaded in the wait cycle, so they stand at the edge
  // where waitrequest is low and hold until the next read.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      if (avs_address[4] == ADDR_HI_BANK) begin
        // Upper bank holds only the result low byte
        avs_readdata <= (avs_address[3:0] == ADDR_RES_LO) ? {24'h000000, result_low_byte}
                                                        : 32'h0000_0000;
      end else begin
        // Busy reads live, so a finished conversion shows idle at once
        unique case (avs_address[3:0])
          ADDR_CTRL0: avs_readdata <= {24'h000000, converter_control_zero[7:2],
                                       busy_reg, converter_control_zero[0]};
          ADDR_CTRL1: avs_readdata <= {24'h000000, converter_reference_port_config};
          ADDR_CTRL2: avs_readdata <= {24'h000000, converter_timing_format};
          ADDR_RES_HI: avs_readdata <= {24'h000000, result_high_byte};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : adcctl_top

// ### tb/adcctl_props.sv
// Checker for the converter control block, bound to its top module.
// Assumes one clock domain and the byte map of the register bus.
`timescale 1ns/1ps
module adcctl_props
  import adcctl_pkg::*;
#(
  parameter int N_INPUTS = NUM_INPUTS,
  parameter int RES_W = RESULT_BITS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Analog side
  input wire adcctl_sel_t analog_sel,
  input wire logic [N_INPUTS-1:0] pin_is_analog,
  input wire logic conv_clk_tick,
  input wire logic conversion_done_flag
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic wr0;
  logic wr1;
  // Accepted writes to control zero and control one
  assign wr0 = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 5'h00;
  assign wr1 = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 5'h04;
  function automatic logic [11:0] amap(logic [3:0] c);
    amap = (c <= 4'h3) ? 12'hFFF : (c == 4'hF) ? 12'h000 : 12'hFFF >> (c - 4'h3);
  endfunction : amap
  sequence s_rd_first;
    avs_read && avs_waitrequest;
  endsequence
  sequence s_rd_done;
    !avs_waitrequest || !avs_read;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_write_wait: assert property (avs_write && avs_waitrequest |=> !avs_waitrequest)
    else $error("write wait too long");
  chk_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  chk_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without wait");
  chk_read_answer: assert property (s_rd_first |=> s_rd_done)
    else $error("read wait too long");
  chk_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_pin_config: assert property (wr1 |-> ##2 pin_is_analog == amap($past(avs_writedata[3:0], 2)))
    else $error("pin map wrong");
  chk_chan_follow: assert property (wr0 |-> ##2 analog_sel.channel == $past(avs_writedata[5:2], 2))
    else $error("channel not passed on");
  chk_ref_follow: assert property (wr1 |-> ##2 {analog_sel.neg_ref_ext, analog_sel.pos_ref_ext} == $past(avs_writedata[5:4], 2))
    else $error("reference select not passed on");
  chk_done_pulse: assert property (conversion_done_flag |=> !conversion_done_flag)
    else $error("done longer than one cycle");
  chk_done_tick: assert property (conversion_done_flag |-> conv_clk_tick)
    else $error("done without last tick");
  chk_tick_gap: assert property (conv_clk_tick |=> !conv_clk_tick)
    else $error("tick period below two");
  chk_off_quiet: assert property (wr0 && !avs_writedata[0] |-> ##2 !conversion_done_flag [*6])
    else $error("done after disable");
endmodule : adcctl_props

// ### tb/adcctl_analog_model.sv
// Model of the sample-and-hold and comparator array.
// Assumes the block samples the word through its own synchroniser.
`timescale 1ns/1ps
module adcctl_analog_model
  import adcctl_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Selection from the block
  input wire adcctl_sel_t sel,
  // Comparator word
  output logic [9:0] result
);
  logic [9:0] float_reg = 10'h000;
  // A floating node wanders every cycle
  always @(posedge ref_clk) float_reg <= float_reg + 10'h13B;
  // Twelve inputs, level set by channel and both references
  always_comb result = (sel.channel > 4'hB) ? float_reg :
    ({sel.channel, sel.neg_ref_ext, sel.pos_ref_ext, 4'h5} ^ 10'h2C3);
endmodule : adcctl_analog_model

// ### tb/adcctl_tb.sv
// Testbench for the converter control block.
// Assumes the analog model on the far side and the checker bound below.
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, sample_on, conv_clk_tick, conversion_done_flag;
  adcctl_pkg::adcctl_sel_t analog_sel;
  logic [11:0] pin_is_analog;
  logic [9:0] comparator_result;
  int bad_count = 0, num_checks = 0, cyc = 0, done_cyc = 0, done_n = 0, start_cyc = 0;
  localparam int DIVS [8] = '{2, 8, 32, 8, 4, 16, 64, 8};
  localparam int ACQS [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  // Clock of 40 ns
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  adcctl_top dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .analog_sel(analog_sel),
    .pin_is_analog(pin_is_analog), .sample_on(sample_on), .conv_clk_tick(conv_clk_tick),
    .comparator_result(comparator_result), .conversion_done_flag(conversion_done_flag));
  adcctl_analog_model model_u (.ref_clk(ref_clk), .sel(analog_sel), .result(comparator_result));
  // Count edges and completion pulses
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (conversion_done_flag === 1'b1) begin
      done_cyc <= cyc;
      done_n <= done_n + 1;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One bus transfer: raised after a rising edge, held until waitrequest is seen low
  task bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    start_cyc = cyc;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr
  task rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    check(q, {24'h0, e});
  endtask : rd
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rd(5'h00, 8'h00);
    rd(5'h04, 8'h00);
    rd(5'h08, 8'h00);
    wr(5'h00, 8'hFC);
    wr(5'h04, 8'hFF);
    wr(5'h08, 8'hFF);
    rd(5'h00, 8'h3C);
    rd(5'h04, 8'h3F);
    rd(5'h08, 8'hBF);
    bus(1'b1, 5'h04, 8'h00, 4'hE);
    rd(5'h04, 8'h3F);
    rd(5'h14, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task t_pins;
    logic [11:0] e;
    for (int k = 0; k < 16; k++) begin
      e = (k < 4) ? 12'hFFF : (k == 15) ? 12'h000 : 12'hFFF >> (k - 3);
      wr(5'h04, 8'(k));
      @(negedge ref_clk);
      check(pin_is_analog, e);
    end
    $display("test pins done");
  endtask : t_pins
  // Full conversion: channel, refs, format, acquisition and clock from c
  task conv(input logic [3:0] c);
    logic [2:0] k;
    logic [9:0] v;
    logic rj;
    int lo, hi, n0, s;
    k = c[2:0] ^ {c[3], 2'b00};
    rj = c[0] ^ c[3];
    lo = (ACQS[c[2:0]] + 11) * DIVS[k];
    hi = lo + DIVS[k] + ((k[1:0] == 2'b11) ? 4 : 1) + 2;
    v = {c, c[1:0], 4'h5} ^ 10'h2C3;
    wr(5'h04, {2'b00, c[1:0], 4'h0});
    @(negedge ref_clk);
    check({analog_sel.neg_ref_ext, analog_sel.pos_ref_ext}, c[1:0]);
    wr(5'h08, {rj, 1'b0, c[2:0], k});
    n0 = done_n;
    wr(5'h00, {2'b00, c, 2'b11});
    s = start_cyc;
    rd(5'h00, {2'b00, c, 2'b11});
    for (int i = 0; i < 3000 && done_n == n0; i++) @(negedge ref_clk);
    check(done_cyc - s >= lo && done_cyc - s <= hi, 1'b1);
    rd(5'h00, {2'b00, c, 2'b01});
    check(sample_on, 1'b1);
    if (c < 4'hC) begin
      rd(5'h0C, rj ? {6'h00, v[9:8]} : v[9:2]);
      rd(5'h10, rj ? v[7:0] : {v[1:0], 6'h00});
    end
  endtask : conv
  task t_abort;
    int n0;
    wr(5'h08, 8'h3E);
    wr(5'h00, 8'h02);
    rd(5'h00, 8'h00);
    wr(5'h00, 8'h17);
    rd(5'h00, 8'h17);
    wr(5'h00, 8'h14);
    rd(5'h00, 8'h14);
    check(sample_on, 1'b0);
    n0 = done_n;
    repeat (2500) @(negedge ref_clk);
    check(done_n, n0);
    wr(5'h00, 8'h17);
    repeat (50) @(posedge ref_clk);
    check(sample_on, 1'b1);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(5'h00, 8'h00);
    rd(5'h08, 8'h00);
    check(sample_on, 1'b0);
    repeat (2500) @(negedge ref_clk);
    check(done_n, n0);
    $display("test abort done");
  endtask : t_abort
  // Watchdog against a hang
  initial begin
    #2400000;
    bad_count++;
    final_report;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_pins;
    for (int c = 0; c < 16; c++) conv(4'(c));
    $display("test conversions done");
    t_abort;
    final_report;
  end
endmodule : tb
bind adcctl_top adcctl_props #(.N_INPUTS(N_INPUTS), .RES_W(RES_W)) chk_u (.ref_clk(ref_clk),
  .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .analog_sel(analog_sel),
  .pin_is_analog(pin_is_analog), .conv_clk_tick(conv_clk_tick),
  .conversion_done_flag(conversion_done_flag));
